// [rtl/cs_drive.sv]
/*
  drive end: cyclic synchronous position and velocity setpoint logic.
  assumes the host keeps one link transfer per cycle; act_pos/act_vel
  come from the encoder path synchronous to mclk.
*/
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module cs_drive import cs_pkg::*; #(
  parameter int unsigned MS_CYCLES = MS_CYCLES_DEF
) (
  input  wire logic               mclk,
  input  wire logic               rstn,
  input  wire logic               ce,
  cs_link_if.dev                  lk,
  input  wire logic signed [31:0] act_pos,
  input  wire logic signed [31:0] act_vel,
  input  wire logic               closed_loop,
  input  wire logic               drive_en,
  input  wire logic               quick_stop,
  output logic signed [31:0]      dem_pos,
  output logic signed [31:0]      dem_vel,
  output logic signed [31:0]      trq_off,
  output logic                    power_on,
  output logic [15:0]             status
);
  typedef logic signed [31:0] s32_t;

  function automatic s32_t clamp(input s32_t v, input s32_t lo, input s32_t hi);
    clamp = (v > hi) ? hi : ((v < lo) ? lo : v);
  endfunction

  logic [7:0]  mode_r, mode_nxt, iidx_r, iidx_nxt;
  s32_t        tpos_r, tpos_nxt, tvel_r, tvel_nxt, pmin_r, pmin_nxt, pmax_r, pmax_nxt;
  s32_t        fewin_r, fewin_nxt, qsdec_r, qsdec_nxt, maxspd_r, maxspd_nxt;
  s32_t        poff_r, poff_nxt, voff_r, voff_nxt, dpos_r, dpos_nxt, dvel_r, dvel_nxt;
  s32_t        toff_r, toff_nxt, rdata_r, rdata_nxt;
  logic [15:0] feto_r, feto_nxt, qsopt_r, qsopt_nxt, iper_r, iper_nxt;
  logic [15:0] cyc_r, cyc_nxt, age_r, age_nxt, fecnt_r, fecnt_nxt, stat_r, stat_nxt;
  logic [31:0] ms_r, ms_nxt;
  logic        rlim_r, rlim_nxt, pol_r, pol_nxt, insync_r, insync_nxt;
  logic        fe_r, fe_nxt, lim_r, lim_nxt, rack_r, rack_nxt, pwr_r, pwr_nxt;

  logic        ms_tick, cyc_tick, pos_mode, vel_mode, follow, outside, upd;
  s32_t        praw, vraw, ferr, vlim;

  always_comb begin
    mode_nxt   = mode_r;
    iidx_nxt   = iidx_r;
    tpos_nxt   = tpos_r;
    tvel_nxt   = tvel_r;
    pmin_nxt   = pmin_r;
    pmax_nxt   = pmax_r;
    rlim_nxt   = rlim_r;
    fewin_nxt  = fewin_r;
    feto_nxt   = feto_r;
    qsdec_nxt  = qsdec_r;
    qsopt_nxt  = qsopt_r;
    maxspd_nxt = maxspd_r;
    iper_nxt   = iper_r;
    poff_nxt   = poff_r;
    voff_nxt   = voff_r;
    toff_nxt   = toff_r;
    pol_nxt    = pol_r;
    // link writes: a repeated target just overwrites, so repeats are harmless
    if (lk.wr) begin
      unique case (lk.idx)
        OB_MODE:   mode_nxt   = lk.wdata[7:0];
        OB_TPOS:   tpos_nxt   = lk.wdata;
        OB_TVEL:   tvel_nxt   = lk.wdata;
        OB_PMIN:   pmin_nxt   = lk.wdata;
        OB_PMAX:   pmax_nxt   = lk.wdata;
        OB_RLIM:   rlim_nxt   = lk.wdata[0];
        OB_FEWIN:  fewin_nxt  = lk.wdata;
        OB_FETO:   feto_nxt   = lk.wdata[15:0];
        OB_QSDEC:  qsdec_nxt  = lk.wdata;
        OB_QSOPT:  qsopt_nxt  = lk.wdata[15:0];
        OB_MAXSPD: maxspd_nxt = lk.wdata;
        OB_IPER:   iper_nxt   = lk.wdata[15:0];
        OB_IIDX:   if (lk.wdata[7:0] == IDX_MS) iidx_nxt = lk.wdata[7:0];
        OB_POFF:   poff_nxt   = lk.wdata;
        OB_VOFF:   voff_nxt   = lk.wdata;
        OB_TOFF:   toff_nxt   = lk.wdata;
        OB_POL:    pol_nxt    = lk.wdata[0];
        default:   ;
      endcase
    end
  end

  always_comb begin
    pos_mode = (mode_r == MODE_CSP);
    vel_mode = (mode_r == MODE_CSV);
    // only the 1 ms base is accepted, so period counts milliseconds
    ms_tick  = (ms_r == MS_CYCLES - 1);
    cyc_tick = ms_tick && (cyc_r + 16'h0001 >= iper_r);
    // no controlword bit gates following: enable, valid mode, operational state and no quick stop suffice
    follow   = (pos_mode || vel_mode) && drive_en && lk.nmt_op && !quick_stop;
    upd      = follow && (insync_r ? lk.sync : cyc_tick);
    praw     = tpos_r + poff_r;
    vraw     = tvel_r + voff_r;
    ferr     = dpos_r - act_pos;
    outside  = (ferr > fewin_r) || (ferr < -fewin_r);
    vlim     = clamp(vraw, -maxspd_r, maxspd_r);
    if (pos_mode && !closed_loop) vlim = vraw;
    if (pol_r) vlim = -vlim;

    ms_nxt  = ms_tick ? 32'h0000_0000 : ms_r + 32'h0000_0001;
    cyc_nxt = cyc_tick ? 16'h0000 : (ms_tick ? cyc_r + 16'h0001 : cyc_r);

    // sync tracking runs only in operational state; lost after two silent cycles
    insync_nxt = insync_r;
    age_nxt    = age_r;
    if (!lk.nmt_op) begin
      insync_nxt = 1'b0;
      age_nxt    = 16'h0000;
    end else if (lk.sync) begin
      insync_nxt = 1'b1;
      age_nxt    = 16'h0000;
    end else if (ms_tick) begin
      age_nxt = (age_r == 16'hFFFF) ? age_r : age_r + 16'h0001;
      if (age_r >= iper_r * SYNC_LOSS_MUL) insync_nxt = 1'b0;
    end

    // demands jump straight to the preset; only quick stop ramps dem_vel down by qsdec_r per ms
    dpos_nxt = dpos_r;
    dvel_nxt = dvel_r;
    lim_nxt  = lim_r;
    pwr_nxt  = pwr_r;
    if (quick_stop) begin
      pwr_nxt = (qsopt_r != QS_COAST);
      if (ms_tick) begin
        if (dvel_r > qsdec_r)       dvel_nxt = dvel_r - qsdec_r;
        else if (dvel_r < -qsdec_r) dvel_nxt = dvel_r + qsdec_r;
        else                        dvel_nxt = 32'sh0000_0000;
      end
    end else begin
      pwr_nxt = drive_en;
      if (upd) begin
        if (pos_mode) begin
          lim_nxt  = (praw > pmax_r) || (praw < pmin_r);
          dpos_nxt = rlim_r ? clamp(praw, pmin_r, pmax_r) : praw;
          dvel_nxt = vlim;
        end else begin
          lim_nxt  = 1'b0;
          dvel_nxt = vlim;
        end
      end
    end

    // following-error timer counts whole milliseconds spent outside
    fecnt_nxt = fecnt_r;
    fe_nxt    = fe_r;
    if (!pos_mode || !outside) begin
      fecnt_nxt = 16'h0000;
      fe_nxt    = 1'b0;
    end else if (ms_tick) begin
      if (fecnt_r > feto_r) fe_nxt = 1'b1;
      else fecnt_nxt = fecnt_r + 16'h0001;
    end

    stat_nxt            = 16'h0000;
    stat_nxt[SB_SYNC]   = insync_nxt;
    stat_nxt[SB_LIMIT]  = lim_nxt && pos_mode;
    stat_nxt[SB_FOLLOW] = follow;
    stat_nxt[SB_FERR]   = fe_nxt && pos_mode;

    rack_nxt  = lk.rd;
    rdata_nxt = 32'h0000_0000;
    if (lk.rd) begin
      unique case (lk.idx)
        OB_STATUS: rdata_nxt = {16'h0000, stat_r};
        OB_APOS:   rdata_nxt = pos_mode ? act_pos : 32'sh0000_0000;
        OB_AVEL:   rdata_nxt = act_vel;
        OB_AFE:    rdata_nxt = pos_mode ? ferr : 32'sh0000_0000;
        OB_POL:    rdata_nxt = {31'h0000_0000, pol_r};
        OB_DPOS:   rdata_nxt = dpos_r;
        OB_MODE:   rdata_nxt = {24'h00_0000, mode_r};
        OB_IIDX:   rdata_nxt = {{24{iidx_r[7]}}, iidx_r};
        OB_IPER:   rdata_nxt = {16'h0000, iper_r};
        default:   rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mode_r <= 8'h00;  iidx_r <= IDX_MS;  tpos_r <= 32'sh0;  tvel_r <= 32'sh0;
      pmin_r <= 32'sh8000_0000;  pmax_r <= 32'sh7FFF_FFFF;  rlim_r <= 1'b1;
      fewin_r <= 32'sh0000_0100;  feto_r <= 16'h0064;  qsdec_r <= 32'sh0000_0001;
      qsopt_r <= 16'h0001;  maxspd_r <= 32'sh7FFF_FFFF;  iper_r <= 16'h0001;
      poff_r <= 32'sh0;  voff_r <= 32'sh0;  toff_r <= 32'sh0;  pol_r <= 1'b0;
      ms_r <= 32'h0;  cyc_r <= 16'h0;  age_r <= 16'h0;  insync_r <= 1'b0;
      dpos_r <= 32'sh0;  dvel_r <= 32'sh0;  lim_r <= 1'b0;  pwr_r <= 1'b0;
      fecnt_r <= 16'h0;  fe_r <= 1'b0;  stat_r <= 16'h0;  rack_r <= 1'b0;
      rdata_r <= 32'sh0;
    end else if (ce) begin
      mode_r <= mode_nxt;  iidx_r <= iidx_nxt;  tpos_r <= tpos_nxt;  tvel_r <= tvel_nxt;
      pmin_r <= pmin_nxt;  pmax_r <= pmax_nxt;  rlim_r <= rlim_nxt;
      fewin_r <= fewin_nxt;  feto_r <= feto_nxt;  qsdec_r <= qsdec_nxt;
      qsopt_r <= qsopt_nxt;  maxspd_r <= maxspd_nxt;  iper_r <= iper_nxt;
      poff_r <= poff_nxt;  voff_r <= voff_nxt;  toff_r <= toff_nxt;  pol_r <= pol_nxt;
      ms_r <= ms_nxt;  cyc_r <= cyc_nxt;  age_r <= age_nxt;  insync_r <= insync_nxt;
      dpos_r <= dpos_nxt;  dvel_r <= dvel_nxt;  lim_r <= lim_nxt;  pwr_r <= pwr_nxt;
      fecnt_r <= fecnt_nxt;  fe_r <= fe_nxt;  stat_r <= stat_nxt;  rack_r <= rack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign dem_pos  = dpos_r;
  assign dem_vel  = dvel_r;
  assign trq_off  = toff_r;
  assign power_on = pwr_r;
  assign status   = stat_r;
  assign lk.rack  = rack_r;
  assign lk.rdata = rdata_r;
endmodule
`default_nettype wire

// [rtl/cs_host.sv]
/*
  host end: AXI4-Lite register slave that drives the object link,
  emits periodic sync and resends the target on every sync.
  assumes one AXI master with one write and one read outstanding.
*/
`timescale 1ns/1ps
`default_nettype none
module cs_host import cs_pkg::*; (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        ce,
  cs_link_if.host          lk,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    merge = o;
    for (int i = 0; i < 4; i++) if (s[i]) merge[8*i +: 8] = n[8*i +: 8];
  endfunction

  logic [31:0] ctrl_r, ctrl_nxt, per_r, per_nxt, tgt_r, tgt_nxt, cmd_r, cmd_nxt;
  logic [31:0] dat_r, dat_nxt, res_r, res_nxt, pcnt_r, pcnt_nxt, wd_r, wd_nxt;
  logic [31:0] ardata_r, ardata_nxt, lwd_r, lwd_nxt;
  logic [7:0]  awa_r, awa_nxt, lidx_r, lidx_nxt;
  logic [3:0]  ws_r, ws_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic        awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt, bv_r, bv_nxt, arrdy_r, arrdy_nxt;
  logic        rv_r, rv_nxt, pend_r, pend_nxt, wait_r, wait_nxt, done_r, done_nxt;
  logic        lwr_r, lwr_nxt, lrd_r, lrd_nxt, sync_r, sync_nxt;
  logic        have_aw, have_w, fire;

  always_comb begin
    {ctrl_nxt, per_nxt, tgt_nxt, cmd_nxt, dat_nxt} = {ctrl_r, per_r, tgt_r, cmd_r, dat_r};
    {res_nxt, awa_nxt, wd_nxt, ws_nxt, ardata_nxt} = {res_r, awa_r, wd_r, ws_r, ardata_r};
    {awrdy_nxt, wrdy_nxt, bv_nxt, bresp_nxt} = {awrdy_r, wrdy_r, bv_r, bresp_r};
    {arrdy_nxt, rv_nxt, rresp_nxt} = {arrdy_r, rv_r, rresp_r};
    {pend_nxt, wait_nxt, done_nxt} = {pend_r, wait_r, done_r};
    // address and data may come in either order; each is held until both are in
    if (s_axi_awvalid && awrdy_r) begin
      awa_nxt   = s_axi_awaddr;
      awrdy_nxt = 1'b0;
    end
    if (s_axi_wvalid && wrdy_r) begin
      wd_nxt   = s_axi_wdata;
      ws_nxt   = s_axi_wstrb;
      wrdy_nxt = 1'b0;
    end
    have_aw = !awrdy_r && !bv_r;
    have_w  = !wrdy_r && !bv_r;
    if (have_aw && have_w) begin
      bv_nxt    = 1'b1;
      bresp_nxt = RESP_OK;
      unique case (awa_r)
        A_CTRL:   ctrl_nxt = merge(ctrl_r, wd_r, ws_r);
        A_PERIOD: per_nxt  = merge(per_r, wd_r, ws_r);
        A_TARGET: tgt_nxt  = merge(tgt_r, wd_r, ws_r);
        A_OBJDAT: dat_nxt  = merge(dat_r, wd_r, ws_r);
        A_OBJCMD: begin
          cmd_nxt  = merge(cmd_r, wd_r, ws_r);
          pend_nxt = 1'b1;
          done_nxt = 1'b0;
        end
        A_RDATA, A_STAT: ;
        default:  bresp_nxt = RESP_ERR;
      endcase
    end
    if (bv_r && s_axi_bready) begin
      bv_nxt    = 1'b0;
      awrdy_nxt = 1'b1;
      wrdy_nxt  = 1'b1;
    end
    if (s_axi_arvalid && arrdy_r) begin
      arrdy_nxt = 1'b0;
      rv_nxt    = 1'b1;
      rresp_nxt = RESP_OK;
      unique case (s_axi_araddr)
        A_CTRL:   ardata_nxt = ctrl_r;
        A_PERIOD: ardata_nxt = per_r;
        A_TARGET: ardata_nxt = tgt_r;
        A_OBJCMD: ardata_nxt = cmd_r;
        A_OBJDAT: ardata_nxt = dat_r;
        A_RDATA:  ardata_nxt = res_r;
        A_STAT:   ardata_nxt = {30'h0000_0000, done_r, pend_r || wait_r};
        default: begin
          ardata_nxt = 32'h0000_0000;
          rresp_nxt  = RESP_ERR;
        end
      endcase
    end
    if (rv_r && s_axi_rready) begin
      rv_nxt    = 1'b0;
      arrdy_nxt = 1'b1;
    end

    // sync generator: period counted in mclk cycles while operational and running
    pcnt_nxt = pcnt_r;
    fire     = 1'b0;
    if (ctrl_r[0] && ctrl_r[1] && per_r != 32'h0000_0000) begin
      fire     = (pcnt_r + 32'h0000_0001 >= per_r);
      pcnt_nxt = fire ? 32'h0000_0000 : pcnt_r + 32'h0000_0001;
    end else begin
      pcnt_nxt = 32'h0000_0000;
    end
    sync_nxt = fire;
    lwr_nxt  = 1'b0;
    lrd_nxt  = 1'b0;
    lidx_nxt = lidx_r;
    lwd_nxt  = lwd_r;
    // a sync cycle carries the fresh target, queued object access waits a cycle
    if (fire) begin
      lwr_nxt  = 1'b1;
      lidx_nxt = ctrl_r[2] ? OB_TVEL : OB_TPOS;
      lwd_nxt  = tgt_r;
    end else if (pend_r && !wait_r) begin
      pend_nxt = 1'b0;
      lidx_nxt = cmd_r[7:0];
      lwd_nxt  = dat_r;
      if (cmd_r[CMD_RD]) begin
        lrd_nxt  = 1'b1;
        wait_nxt = 1'b1;
      end else begin
        lwr_nxt  = 1'b1;
        done_nxt = 1'b1;
      end
    end
    if (wait_r && lk.rack) begin
      wait_nxt = 1'b0;
      done_nxt = 1'b1;
      res_nxt  = lk.rdata;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= 32'h0;  per_r <= 32'h0;  tgt_r <= 32'h0;  cmd_r <= 32'h0;
      dat_r <= 32'h0;  res_r <= 32'h0;  pcnt_r <= 32'h0;  wd_r <= 32'h0;
      ardata_r <= 32'h0;  lwd_r <= 32'h0;  awa_r <= 8'h0;  lidx_r <= 8'h0;
      ws_r <= 4'h0;  bresp_r <= RESP_OK;  rresp_r <= RESP_OK;
      awrdy_r <= 1'b1;  wrdy_r <= 1'b1;  bv_r <= 1'b0;  arrdy_r <= 1'b1;
      rv_r <= 1'b0;  pend_r <= 1'b0;  wait_r <= 1'b0;  done_r <= 1'b0;
      lwr_r <= 1'b0;  lrd_r <= 1'b0;  sync_r <= 1'b0;
    end else if (ce) begin
      ctrl_r <= ctrl_nxt;  per_r <= per_nxt;  tgt_r <= tgt_nxt;  cmd_r <= cmd_nxt;
      dat_r <= dat_nxt;  res_r <= res_nxt;  pcnt_r <= pcnt_nxt;  wd_r <= wd_nxt;
      ardata_r <= ardata_nxt;  lwd_r <= lwd_nxt;  awa_r <= awa_nxt;  lidx_r <= lidx_nxt;
      ws_r <= ws_nxt;  bresp_r <= bresp_nxt;  rresp_r <= rresp_nxt;
      awrdy_r <= awrdy_nxt;  wrdy_r <= wrdy_nxt;  bv_r <= bv_nxt;  arrdy_r <= arrdy_nxt;
      rv_r <= rv_nxt;  pend_r <= pend_nxt;  wait_r <= wait_nxt;  done_r <= done_nxt;
      lwr_r <= lwr_nxt;  lrd_r <= lrd_nxt;  sync_r <= sync_nxt;
    end
  end

  assign s_axi_awready = awrdy_r;
  assign s_axi_wready  = wrdy_r;
  assign s_axi_bvalid  = bv_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arrdy_r;
  assign s_axi_rvalid  = rv_r;
  assign s_axi_rdata   = ardata_r;
  assign s_axi_rresp   = rresp_r;
  assign lk.wr     = lwr_r;
  assign lk.rd     = lrd_r;
  assign lk.idx    = lidx_r;
  assign lk.wdata  = lwd_r;
  assign lk.sync   = sync_r;
  assign lk.nmt_op = ctrl_r[0];
endmodule
`default_nettype wire

// [rtl/cs_link_if.sv]
/*
  fieldbus object link between host and drive.
  assumes both ends share mclk; every strobe lasts one cycle.
*/
`timescale 1ns/1ps
`default_nettype none
interface cs_link_if;
  logic        wr;
  logic        rd;
  logic [7:0]  idx;
  logic [31:0] wdata;
  logic        sync;
  logic        nmt_op;
  logic        rack;
  logic [31:0] rdata;
  modport dev  (input wr, rd, idx, wdata, sync, nmt_op, output rack, rdata);
  modport host (output wr, rd, idx, wdata, sync, nmt_op, input rack, rdata);
endinterface
`default_nettype wire

// [rtl/cs_pkg.sv]
/*
  constants shared by both ends of the cyclic setpoint link.
  assumes a single 200 MHz clock and one object transfer per link cycle.
*/
// Behaviour
// - mode code 8 selects cyclic position
// - mode code 9 selects cyclic velocity
// - no control bit needed to act
// - status bit 8 shows sync state
// - status bit 12 shows target followed
// - status bit 13 flags position following error
// - error window symmetric around demand
// - error only after timeout in milliseconds
// - status bit 11 flags limit exceeded
// - targets held within software limits
// - cycle equals period times ten power index
// - only index -3, one millisecond base
// - host writes fresh target every cycle
// - target absolute, repeats change nothing
// - no ramps, presets followed directly
// - sync starts when state is operational
// - host emits regular sync events
// - host sends targets at sync interval
// - offsets added to set values
// - speed limited, position mode closed-loop only
// - quick-stop brakes per deceleration and option
// - actual values readable per mode
package cs_pkg;
  localparam int unsigned CLK_NS        = 5;
  localparam int unsigned TBASE_NS      = 1000000;
  localparam int unsigned MS_CYCLES_DEF = TBASE_NS / CLK_NS;
  localparam logic [7:0]  MODE_CSP      = 8'h08;
  localparam logic [7:0]  MODE_CSV      = 8'h09;
  localparam logic [7:0]  IDX_MS        = 8'hFD;
  localparam int          SB_SYNC       = 8;
  localparam int          SB_LIMIT      = 11;
  localparam int          SB_FOLLOW     = 12;
  localparam int          SB_FERR       = 13;
  localparam logic [15:0] QS_COAST      = 16'h0000;
  localparam logic [15:0] SYNC_LOSS_MUL = 16'h0002;
  // object codes on the link
  localparam logic [7:0]  OB_MODE   = 8'h00;
  localparam logic [7:0]  OB_TPOS   = 8'h01;
  localparam logic [7:0]  OB_TVEL   = 8'h02;
  localparam logic [7:0]  OB_PMIN   = 8'h03;
  localparam logic [7:0]  OB_PMAX   = 8'h04;
  localparam logic [7:0]  OB_RLIM   = 8'h05;
  localparam logic [7:0]  OB_FEWIN  = 8'h06;
  localparam logic [7:0]  OB_FETO   = 8'h07;
  localparam logic [7:0]  OB_QSDEC  = 8'h08;
  localparam logic [7:0]  OB_QSOPT  = 8'h09;
  localparam logic [7:0]  OB_MAXSPD = 8'h0A;
  localparam logic [7:0]  OB_IPER   = 8'h0B;
  localparam logic [7:0]  OB_IIDX   = 8'h0C;
  localparam logic [7:0]  OB_POFF   = 8'h0D;
  localparam logic [7:0]  OB_VOFF   = 8'h0E;
  localparam logic [7:0]  OB_TOFF   = 8'h0F;
  localparam logic [7:0]  OB_POL    = 8'h10;
  localparam logic [7:0]  OB_STATUS = 8'h20;
  localparam logic [7:0]  OB_APOS   = 8'h21;
  localparam logic [7:0]  OB_AVEL   = 8'h22;
  localparam logic [7:0]  OB_AFE    = 8'h23;
  localparam logic [7:0]  OB_DPOS   = 8'h24;
  // host register byte addresses
  localparam logic [7:0]  A_CTRL    = 8'h00;
  localparam logic [7:0]  A_PERIOD  = 8'h04;
  localparam logic [7:0]  A_TARGET  = 8'h08;
  localparam logic [7:0]  A_OBJCMD  = 8'h0C;
  localparam logic [7:0]  A_OBJDAT  = 8'h10;
  localparam logic [7:0]  A_RDATA   = 8'h14;
  localparam logic [7:0]  A_STAT    = 8'h18;
  localparam int          CMD_RD    = 8;
  localparam logic [1:0]  RESP_OK   = 2'h0;
  localparam logic [1:0]  RESP_ERR  = 2'h2;
endpackage

// [verif/cs_link_asserts.sv]
/*
  checker for the host to drive object link.
  assumes the link signals arrive as plain inputs on the shared mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module cs_link_asserts import cs_pkg::*; (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  idx,
  input wire logic [31:0] wdata,
  input wire logic        sync,
  input wire logic        nmt_op,
  input wire logic        rack,
  input wire logic [31:0] rdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  read_answer_a: assert property (rd |=> rack) else $error("read left unanswered");
  answer_cause_a: assert property (rack |-> $past(rd)) else $error("answer without read");
  rack_single_a: assert property (rack |=> !rack) else $error("answer longer than one cycle");
  read_single_a: assert property (rd |=> !rd) else $error("read before answer");
  sync_pulse_a: assert property (sync |=> !sync) else $error("sync not a pulse");
  sync_target_a: assert property (sync |-> wr && (idx == OB_TPOS || idx == OB_TVEL))
    else $error("sync without target");
  read_alone_a: assert property (rd |-> !wr && !sync) else $error("read shares a cycle");
  cmd_gap_a: assert property (wr && !sync |=> !wr || sync) else $error("commands too close");
endmodule
`default_nettype wire

// [verif/cyclic_sync_setpoint_modes_bench.sv]
/*
  bench for host and drive joined by the object link.
  assumes MS_CYCLES 20, so one link millisecond is 20 mclk cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module cyclic_sync_setpoint_modes_bench import cs_pkg::*; ;
  typedef struct {logic [7:0] md; logic [31:0] ctl, tgt, dem; logic [15:0] st;} row_t;
  logic               mclk = 0, rstn = 0, ce = 1, closed_loop = 1;
  logic               drive_en = 0, quick_stop = 0, power_on;
  logic signed [31:0] act_pos = 0, act_vel = 32'h1234, fe_off = 0;
  logic signed [31:0] dem_pos, dem_vel, trq_off;
  logic [15:0]        status;
  logic [7:0]         s_axi_awaddr = 0, s_axi_araddr = 0;
  logic               s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic               s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0]        s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]         s_axi_wstrb = 4'hF;
  logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]         s_axi_bresp, s_axi_rresp;
  int                 n_mismatch = 0, samples_checked = 0;
  row_t rows[4] = '{'{MODE_CSP, 32'h3, 32'h64, 32'h69, 16'h1100},
                    '{MODE_CSP, 32'h3, 32'h7D0, 32'h3E8, 16'h1900},
                    '{MODE_CSP, 32'h3, 32'hFFFFF830, 32'hFFFFFC18, 16'h1900},
                    '{MODE_CSV, 32'h7, 32'h32, 32'h35, 16'h1100}};
  cs_link_if lk();
  cs_host i_cs_host (
    .mclk(mclk), .rstn(rstn), .ce(ce), .lk(lk),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  cs_drive #(.MS_CYCLES(20)) i_cs_drive (
    .mclk(mclk), .rstn(rstn), .ce(ce), .lk(lk), .act_pos(act_pos), .act_vel(act_vel),
    .closed_loop(closed_loop), .drive_en(drive_en), .quick_stop(quick_stop),
    .dem_pos(dem_pos), .dem_vel(dem_vel), .trq_off(trq_off), .power_on(power_on),
    .status(status));
  cs_link_asserts i_cs_link_asserts (.mclk(mclk), .rstn(rstn), .wr(lk.wr), .rd(lk.rd),
    .idx(lk.idx), .wdata(lk.wdata), .sync(lk.sync), .nmt_op(lk.nmt_op), .rack(lk.rack),
    .rdata(lk.rdata));
  always #2.5 mclk = ~mclk;
  // encoder follows demand with a chosen deviation
  always @(posedge mclk) act_pos <= dem_pos + fe_off;
  task automatic end_sim;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic bad(string m);
    $display("BAD %0t %s", $time, m);
    n_mismatch++;
  endtask
  task automatic chk_v(logic [31:0] g, logic [31:0] e);
    samples_checked++;
    if (g !== e) bad($sformatf("got %h exp %h", g, e));
  endtask
  task automatic chk_b(logic g, logic e);
    samples_checked++;
    if (g !== e) bad("flag wrong");
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic axi_wr(logic [7:0] a, logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 99; n++) begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    if (n == 99) begin
      bad("write hangs");
      end_sim;
    end
  endtask
  task automatic axi_rd(logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 99; n++) begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    s_axi_rready <= 1'h0;
    if (n == 99) begin
      bad("read hangs");
      end_sim;
    end
  endtask
  // object access: the link strobe follows one cycle after the command write
  task automatic ow(logic [7:0] c, logic [31:0] v);
    logic [1:0] r;
    axi_wr(A_OBJDAT, v, r);
    axi_wr(A_OBJCMD, {24'h0, c}, r);
    cyc(4);
  endtask
  task automatic orr(logic [7:0] c, output logic [31:0] g);
    logic [1:0] r;
    axi_wr(A_OBJCMD, {23'h0, 1'h1, c}, r);
    cyc(4);
    axi_rd(A_RDATA, g);
  endtask
  initial begin
    logic [31:0] g;
    logic [1:0]  r;
    cyc(5);
    rstn <= 1'h1;
    cyc(1);
    chk_v({16'h0, status}, 32'h0);
    chk_b(power_on, 1'h0);
    drive_en <= 1'h1;
    ow(OB_PMIN, 32'hFFFFFC18);
    ow(OB_PMAX, 32'h3E8);
    ow(OB_POFF, 32'h5);
    ow(OB_VOFF, 32'h3);
    axi_wr(A_PERIOD, 32'h1E, r);
    foreach (rows[i]) begin
      ow(OB_MODE, {24'h0, rows[i].md});
      axi_wr(A_CTRL, rows[i].ctl, r);
      axi_wr(A_TARGET, rows[i].tgt, r);
      cyc(70);
      chk_v(rows[i].md == MODE_CSP ? dem_pos : dem_vel, rows[i].dem);
      chk_v({16'h0, status}, {16'h0, rows[i].st});
      $display("row %0d done", i);
    end
    // still in velocity mode with target 0x32 plus offset 3
    ow(OB_TOFF, 32'h7);
    chk_v(trq_off, 32'h7);
    ow(OB_MAXSPD, 32'h20);
    cyc(70);
    chk_v(dem_vel, 32'h20);
    ow(OB_POL, 32'h1);
    cyc(70);
    chk_v(dem_vel, 32'hFFFFFFE0);
    $display("limits done");
    orr(OB_AVEL, g);
    chk_v(g, 32'h1234);
    ow(OB_IIDX, 32'h2);
    orr(OB_IIDX, g);
    chk_v({24'h0, g[7:0]}, {24'h0, IDX_MS});
    axi_wr(8'h3C, 32'h1, r);
    chk_v({30'h0, r}, {30'h0, RESP_ERR});
    $display("objects done");
    ow(OB_MODE, {24'h0, MODE_CSP});
    axi_wr(A_CTRL, 32'h3, r);
    axi_wr(A_TARGET, 32'h0, r);
    ow(OB_FETO, 32'h2);
    cyc(70);
    fe_off <= 32'h101;
    cyc(20);
    chk_b(status[SB_FERR], 1'h0);
    cyc(80);
    chk_b(status[SB_FERR], 1'h1);
    fe_off <= 32'h100;
    cyc(3);
    chk_b(status[SB_FERR], 1'h0);
    fe_off <= 32'hFFFFFEFF;
    cyc(100);
    chk_b(status[SB_FERR], 1'h1);
    fe_off <= 32'h0;
    $display("following error done");
    axi_wr(A_CTRL, 32'h2, r);
    cyc(70);
    chk_b(status[SB_SYNC], 1'h0);
    axi_wr(A_CTRL, 32'h3, r);
    cyc(70);
    chk_b(status[SB_SYNC], 1'h1);
    // stopping sync must drop the flag after two silent cycle periods
    axi_wr(A_CTRL, 32'h1, r);
    cyc(100);
    chk_b(status[SB_SYNC], 1'h0);
    ow(OB_QSOPT, 32'h0);
    quick_stop <= 1'h1;
    cyc(5);
    chk_b(power_on, 1'h0);
    quick_stop <= 1'h0;
    $display("sync and stop done");
    // second reset in mid-run must bring status and power back to idle
    rstn <= 1'h0;
    cyc(2);
    rstn <= 1'h1;
    cyc(1);
    chk_v({16'h0, status}, 32'h0);
    chk_b(power_on, 1'h0);
    $display("reset done");
    end_sim;
  end
endmodule
`default_nettype wire
